// ### dv/dcst_dram_model.sv
// Memory-side model that flags every command arriving too early
`default_nettype none
module dcst_dram_model
  import dcst_pkg::*;
#(
  parameter int CWL = 9  // Write latency in clocks
) (
  input  wire logic       mclk_in,      // Command clock
  input  wire logic       nrst_in,      // Async reset, active low
  input  wire logic       cmd_stb_in,   // Command on the bus
  input  wire dcst_cmd_t  cmd_code_in,  // Command code
  input  wire logic       cmd_bg_in,    // Bank group
  input  wire logic [1:0] cmd_ba_in,    // Bank
  input  wire logic       crc_dm_en_in, // Write CRC and DM on
  output var  int         viol_out      // Failed spacing checks seen
);
  // ----------------------------------------------------------------
  // Spacing history
  // ----------------------------------------------------------------
  int now, col_any, act_any, ext, b;
  int col_t [2];
  int act_t [2];
  int wst_t [2];
  int rd_t  [8];
  int wr_t  [8];
  int faw_q [4];

  function automatic int nck(input int ps, input int n);
    int c;
    c = (ps + TCK_PS - 1) / TCK_PS;
    return (c < n) ? n : c;
  endfunction : nck

  task automatic need(input int since, input int gap);
    if (now - since < gap) viol_out++;
  endtask : need

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      now = 0;
      viol_out = 0;
      col_any = -999;
      act_any = -999;
      for (int i = 0; i < 8; i++) begin
        rd_t[i] = -999;
        wr_t[i] = -999;
        col_t[i % 2] = -999;
        act_t[i % 2] = -999;
        wst_t[i % 2] = -999;
        faw_q[i % 4] = -999;
      end
    end else begin
      now = now + 1;
      b = {cmd_bg_in, cmd_ba_in};
      ext = crc_dm_en_in ? nck(CRC_DM_PS, CRC_DM_NCK) : 0;
      if (cmd_stb_in) begin
        case (cmd_code_in)
          DCST_ACT: begin
            need(act_t[cmd_bg_in], nck(RRD_L_PS, RRD_NCK));
            need(act_any, nck(RRD_S_PS, RRD_NCK));
            need(faw_q[0], nck(FAW_PS, FAW_NCK));
            faw_q = '{faw_q[1], faw_q[2], faw_q[3], now};
            act_t[cmd_bg_in] = now;
            act_any = now;
          end
          DCST_RD, DCST_WR: begin
            need(col_t[cmd_bg_in], nck(CCD_L_PS, CCD_L_NCK));
            need(col_any, CCD_S_NCK);
            col_t[cmd_bg_in] = now;
            col_any = now;
            if (cmd_code_in == DCST_RD) begin
              need(wst_t[cmd_bg_in], nck(WTR_L_PS, WTR_L_NCK) + ext);
              need(wst_t[!cmd_bg_in], nck(WTR_S_PS, WTR_S_NCK) + ext);
              rd_t[b] = now;
            end else begin
              wst_t[cmd_bg_in] = now + CWL + BURST_HALF;
              wr_t[b] = now;
            end
          end
          DCST_PRE: begin
            need(rd_t[b], nck(RTP_PS, RTP_NCK));
            need(wr_t[b] + CWL + BURST_HALF, nck(WR_PS, WR_NCK) + ext);
          end
          default: ;
        endcase
      end
    end
  end
endmodule : dcst_dram_model
`default_nettype wire

// ### dv/dcst_sched_tb.sv
// Self-checking bench for the command spacing timer
`default_nettype none
module dcst_sched_tb import dcst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CWL = 9;
  logic       mclk_in, nrst_in, req_valid_in, crc_dm_en_in, req_ready_out, cmd_stb_out;
  dcst_cmd_t  req_cmd_in, cmd_code_out;
  logic       req_bg_in, cmd_bg_out;
  logic [1:0] req_ba_in, cmd_ba_out;
  int         cyc = 0, errors = 0, n_checks = 0, viol;

  dcst_sched #(.NBG(2), .BPG(4), .CWL(CWL)) uut (.mclk_in, .nrst_in, .req_valid_in,
    .req_cmd_in, .req_bg_in, .req_ba_in, .crc_dm_en_in, .req_ready_out, .cmd_stb_out,
    .cmd_code_out, .cmd_bg_out, .cmd_ba_out);
  dcst_dram_model #(.CWL(CWL)) dram (.mclk_in, .nrst_in, .cmd_stb_in(cmd_stb_out),
    .cmd_code_in(cmd_code_out), .cmd_bg_in(cmd_bg_out), .cmd_ba_in(cmd_ba_out),
    .crc_dm_en_in, .viol_out(viol));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask : check

  function automatic int nck(input int ps, input int n);
    int c;
    c = (ps + TCK_PS - 1) / TCK_PS;
    return (c < n) ? n : c;
  endfunction : nck

  task automatic present(input dcst_cmd_t c, input logic bg, input logic [1:0] ba);
    int k;
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_cmd_in   <= c;
    req_bg_in    <= bg;
    req_ba_in    <= ba;
    for (k = 0; k < 100; k++) begin
      @(negedge mclk_in);
      if (req_ready_out === 1'b1) break;
    end
    if (k == 100) begin
      errors++;
      test_done();
    end
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
  endtask : present

  task automatic wait_stb(input dcst_cmd_t c, input logic bg, input logic [1:0] ba,
                          output int t);
    int k;
    for (k = 0; k < 100; k++) begin
      @(negedge mclk_in);
      if (cmd_stb_out === 1'b1) break;
    end
    if (k == 100) begin
      errors++;
      test_done();
    end
    t = cyc;
    check({26'h0, cmd_code_out, cmd_bg_out, cmd_ba_out}, {26'h0, c, bg, ba});
  endtask : wait_stb

  task automatic send(input dcst_cmd_t c, input logic bg, input logic [1:0] ba,
                      output int t);
    present(c, bg, ba);
    wait_stb(c, bg, ba, t);
  endtask : send

  // Idle first so no older command still constrains the pair
  task automatic pair(input dcst_cmd_t c1, input logic bg1, input logic [1:0] ba1,
                      input dcst_cmd_t c2, input logic bg2, input logic [1:0] ba2,
                      input int gap);
    int t1, t2;
    repeat (40) @(posedge mclk_in);
    send(c1, bg1, ba1, t1);
    send(c2, bg2, ba2, t2);
    check(32'(t2 - t1), 32'(gap));
  endtask : pair

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_column();
    pair(DCST_RD, 1'b0, 2'h0, DCST_RD, 1'b0, 2'h1, nck(CCD_L_PS, CCD_L_NCK));
    pair(DCST_WR, 1'b0, 2'h0, DCST_WR, 1'b1, 2'h0, CCD_S_NCK);
    pair(DCST_WR, 1'b1, 2'h1, DCST_NOP, 1'b1, 2'h1, 2);
    $display("t_column done");
  endtask : t_column

  task automatic t_activate();
    int t [5];
    pair(DCST_ACT, 1'b0, 2'h0, DCST_ACT, 1'b1, 2'h0, nck(RRD_S_PS, RRD_NCK));
    pair(DCST_ACT, 1'b1, 2'h0, DCST_ACT, 1'b1, 2'h1, nck(RRD_L_PS, RRD_NCK));
    repeat (40) @(posedge mclk_in);
    for (int i = 0; i < 5; i++) send(DCST_ACT, i[0], 2'(i / 2), t[i]);
    check(32'(t[4] - t[0]), 32'(nck(FAW_PS, FAW_NCK)));
    $display("t_activate done");
  endtask : t_activate

  task automatic t_refuse();
    int t1, t2;
    repeat (40) @(posedge mclk_in);
    send(DCST_WR, 1'b0, 2'h0, t1);
    present(DCST_RD, 1'b0, 2'h0);
    // Request made while busy must be dropped
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_cmd_in   <= DCST_PRE;
    req_bg_in    <= 1'b1;
    repeat (4) begin
      @(negedge mclk_in);
      check({31'h0, req_ready_out}, 32'h0);
    end
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    wait_stb(DCST_RD, 1'b0, 2'h0, t2);
    check(32'(t2 - t1), 32'(CWL + BURST_HALF + nck(WTR_L_PS, WTR_L_NCK)));
    repeat (12) begin
      @(negedge mclk_in);
      check({31'h0, cmd_stb_out}, 32'h0);
    end
    $display("t_refuse done");
  endtask : t_refuse

  task automatic t_turn(input logic crc);
    int x;
    x = crc ? nck(CRC_DM_PS, CRC_DM_NCK) : 0;
    @(posedge mclk_in);
    crc_dm_en_in <= crc;
    pair(DCST_WR, 1'b0, 2'h0, DCST_RD, 1'b0, 2'h1,
         CWL + BURST_HALF + nck(WTR_L_PS, WTR_L_NCK) + x);
    pair(DCST_WR, 1'b0, 2'h0, DCST_RD, 1'b1, 2'h0,
         CWL + BURST_HALF + nck(WTR_S_PS, WTR_S_NCK) + x);
    pair(DCST_WR, 1'b1, 2'h3, DCST_PRE, 1'b1, 2'h3,
         CWL + BURST_HALF + nck(WR_PS, WR_NCK) + x);
    pair(DCST_RD, 1'b0, 2'h1, DCST_PRE, 1'b0, 2'h1, nck(RTP_PS, RTP_NCK));
    pair(DCST_RD, 1'b0, 2'h1, DCST_PRE, 1'b0, 2'h2, 2);
    $display("t_turn done, crc %0d", crc);
  endtask : t_turn

  initial begin
    nrst_in      = 1'b0;
    req_valid_in = 1'b0;
    req_cmd_in   = DCST_NOP;
    req_bg_in    = 1'b0;
    req_ba_in    = 2'h0;
    crc_dm_en_in = 1'b0;
    repeat (12) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_column();
    t_activate();
    t_refuse();
    t_turn(1'b0);
    t_turn(1'b1);
    repeat (4) @(posedge mclk_in);
    check(32'(viol), 32'h0);
    test_done();
  end
endmodule : dcst_sched_tb
`default_nettype wire

// ### hdl/dcst_faw.sv
// Rolling four-activate window tracker
`default_nettype none
module dcst_faw
  import dcst_pkg::*;
#(
  parameter int NACT = FAW_ACTS,
  parameter int WIN  = FAW_CYC
) (
  input wire logic mclk_in,  // 50 MHz clock
  input wire logic nrst_in,  // Async reset, active low
  dcst_faw_if.win  faw       // Activate pulse and permit
);

  logic [CNT_W-1:0] slot_reg  [NACT];
  logic [CNT_W-1:0] slot_next [NACT];
  logic             free;
  logic             found;

  // ----------------------------------------------------------------
  // One slot per recent activate, cleared when it leaves the window
  // ----------------------------------------------------------------
  // R05 window slots
  always_comb begin
    found = 1'b0;
    free  = 1'b0;
    for (int i = 0; i < NACT; i++) begin
      slot_next[i] = (slot_reg[i] == '0) ? '0 : slot_reg[i] - 1'b1;
      if (slot_reg[i] == '0) free = 1'b1;
      if (faw.act && !found && slot_reg[i] == '0) begin
        slot_next[i] = CNT_W'(WIN - 1);
        found        = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NACT; i++) slot_reg[i] <= '0;
    end else begin
      slot_reg <= slot_next;
    end
  end

  assign faw.allow = free;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [WIN-2:0] hist_reg;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) hist_reg <= '0;
    else          hist_reg <= {hist_reg[WIN-3:0], faw.act};
  end

  faw_count_a: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R05
    faw.act |-> $countones(hist_reg) < NACT)
    else $error("Fifth activate inside the window");

  faw_stall_c: cover property (@(posedge mclk_in) disable iff (!nrst_in)
    !faw.allow ##1 faw.allow);

endmodule : dcst_faw
`default_nettype wire

// ### hdl/dcst_faw_if.sv
// Activate pulse and window permit between the scheduler and the window tracker
`default_nettype none
interface dcst_faw_if;
  logic act;    // Activate issued this cycle
  logic allow;  // Another activate fits the window
  modport ctl (output act, input allow);
  modport win (input act, output allow);
endinterface : dcst_faw_if
`default_nettype wire

// ### hdl/dcst_pkg.sv
// Constants, types and helpers for the DDR4 command spacing timer
//
// Function
// R01: Same-group column commands: max(4 clk, 5 ns)
// R02: Cross-group column commands: at least 4 clk
// R03: Cross-group activates: max(4 clk, 5.3 ns)
// R04: Same-group activates: max(4 clk, 6.4 ns)
// R05: At most four activates per max(28 clk, 30 ns)
// R06: Write end to cross-group read: max(2 clk, 2.5 ns)
// R07: Write end to same-group read: max(4 clk, 7.5 ns)
// R08: Read to precharge same bank: max(4 clk, 7.5 ns)
// R09: Write recovery 15 ns, plus CRC/DM extra
// R10: CRC/DM adds max(5 clk, 3.75 ns) cross-group
// R11: CRC/DM adds max(5 clk, 3.75 ns) same-group
// R12: Round ns up, take larger of both limits
`default_nettype none
package dcst_pkg;

  // ----------------------------------------------------------------
  // Clock and printed limits
  // ----------------------------------------------------------------
  localparam int TCK_PS      = 20000;
  localparam int CCD_L_PS    = 5000;
  localparam int RRD_S_PS    = 5300;
  localparam int RRD_L_PS    = 6400;
  localparam int FAW_PS      = 30000;
  localparam int WTR_S_PS    = 2500;
  localparam int WTR_L_PS    = 7500;
  localparam int RTP_PS      = 7500;
  localparam int WR_PS       = 15000;
  localparam int CRC_DM_PS   = 3750;
  localparam int CCD_L_NCK   = 4;
  localparam int CCD_S_NCK   = 4;
  localparam int RRD_NCK     = 4;
  localparam int FAW_NCK     = 28;
  localparam int WTR_S_NCK   = 2;
  localparam int WTR_L_NCK   = 4;
  localparam int RTP_NCK     = 4;
  localparam int WR_NCK      = 1;
  localparam int CRC_DM_NCK  = 5;
  localparam int BURST_HALF  = 4;
  localparam int FAW_ACTS    = 4;
  localparam int CNT_W       = 8;

  // R12 round up, then larger of the two
  function automatic int dcst_cyc(input int ps, input int nck);
    int c;
    c = (ps + TCK_PS - 1) / TCK_PS;
    if (c < nck) c = nck;
    if (c < 1) c = 1;
    return c;
  endfunction : dcst_cyc

  // ----------------------------------------------------------------
  // Spacing counts in clock cycles
  // ----------------------------------------------------------------
  localparam int CCD_L_CYC  = dcst_cyc(CCD_L_PS, CCD_L_NCK);
  localparam int CCD_S_CYC  = dcst_cyc(0, CCD_S_NCK);
  localparam int RRD_S_CYC  = dcst_cyc(RRD_S_PS, RRD_NCK);
  localparam int RRD_L_CYC  = dcst_cyc(RRD_L_PS, RRD_NCK);
  localparam int FAW_CYC    = dcst_cyc(FAW_PS, FAW_NCK);
  localparam int WTR_S_CYC  = dcst_cyc(WTR_S_PS, WTR_S_NCK);
  localparam int WTR_L_CYC  = dcst_cyc(WTR_L_PS, WTR_L_NCK);
  localparam int RTP_CYC    = dcst_cyc(RTP_PS, RTP_NCK);
  localparam int WR_CYC     = dcst_cyc(WR_PS, WR_NCK);
  localparam int CRC_DM_CYC = dcst_cyc(CRC_DM_PS, CRC_DM_NCK);

  typedef enum logic [2:0] {
    DCST_NOP = 3'h0,
    DCST_ACT = 3'h1,
    DCST_RD  = 3'h2,
    DCST_WR  = 3'h3,
    DCST_PRE = 3'h4
  } dcst_cmd_t;

  typedef enum logic [1:0] {
    DCST_IDLE = 2'h1,
    DCST_HOLD = 2'h2
  } dcst_state_t;

endpackage : dcst_pkg
`default_nettype wire

// ### hdl/dcst_sched.sv
// Command spacing timer: holds each command until every DDR4 spacing limit is met
`default_nettype none
module dcst_sched
  import dcst_pkg::*;
#(
  parameter int NBG = 2,  // Bank groups
  parameter int BPG = 4,  // Banks per group
  parameter int CWL = 9   // Write latency in clocks
) (
  input  wire logic                   mclk_in,       // 50 MHz clock
  input  wire logic                   nrst_in,       // Async reset, active low
  input  wire logic                   req_valid_in,  // Command request
  input  wire dcst_cmd_t              req_cmd_in,    // Requested command
  input  wire logic [$clog2(NBG)-1:0] req_bg_in,     // Requested bank group
  input  wire logic [$clog2(BPG)-1:0] req_ba_in,     // Requested bank
  input  wire logic                   crc_dm_en_in,  // Write CRC and DM both on
  output logic                        req_ready_out, // Request taken
  output logic                        cmd_stb_out,   // Command issued now
  output dcst_cmd_t                   cmd_code_out,  // Issued command
  output logic [$clog2(NBG)-1:0]      cmd_bg_out,    // Issued bank group
  output logic [$clog2(BPG)-1:0]      cmd_ba_out     // Issued bank
);

  localparam int BGW = $clog2(NBG);
  localparam int BAW = $clog2(BPG);
  localparam int NBK = NBG * BPG;
  localparam int BKW = BGW + BAW;
  localparam int WR_END = CWL + BURST_HALF;

  typedef logic [CNT_W-1:0] dcst_cnt_t;

  // Countdown with a load that never shortens a running wait
  function automatic dcst_cnt_t tmr(input dcst_cnt_t cur, input logic ld, input int val);
    dcst_cnt_t d;
    d = (cur == '0) ? '0 : cur - 1'b1;
    if (ld && CNT_W'(val - 1) > d) d = CNT_W'(val - 1);
    return d;
  endfunction : tmr

  // ----------------------------------------------------------------
  // Request hold and state
  // ----------------------------------------------------------------
  dcst_state_t       state_reg, state_next;
  dcst_cmd_t         cmd_reg, cmd_next;
  logic [BGW-1:0]    bg_reg, bg_next;
  logic [BAW-1:0]    ba_reg, ba_next;
  logic              legal;
  logic              issue;
  logic              is_col;
  logic [BKW-1:0]    bk;
  dcst_faw_if        faw ();

  assign is_col = (cmd_reg == DCST_RD) || (cmd_reg == DCST_WR);
  assign bk     = {bg_reg, ba_reg};
  assign issue  = (state_reg == DCST_HOLD) && legal;

  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    bg_next    = bg_reg;
    ba_next    = ba_reg;
    case (state_reg)
      DCST_IDLE: begin
        if (req_valid_in) begin
          state_next = DCST_HOLD;
          cmd_next   = req_cmd_in;
          bg_next    = req_bg_in;
          ba_next    = req_ba_in;
        end
      end
      DCST_HOLD: begin
        if (legal) state_next = DCST_IDLE;
      end
      default: state_next = DCST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= DCST_IDLE;
      cmd_reg   <= DCST_NOP;
      bg_reg    <= '0;
      ba_reg    <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      bg_reg    <= bg_next;
      ba_reg    <= ba_next;
    end
  end

  assign req_ready_out = (state_reg == DCST_IDLE);
  assign cmd_stb_out   = issue;
  assign cmd_code_out  = cmd_reg;
  assign cmd_bg_out    = bg_reg;
  assign cmd_ba_out    = ba_reg;

  // ----------------------------------------------------------------
  // Spacing counters, zero means the next command may go
  // ----------------------------------------------------------------
  dcst_cnt_t ccd_s_reg, ccd_s_next, rrd_s_reg, rrd_s_next, wtr_s_reg, wtr_s_next;
  dcst_cnt_t ccd_l_reg [NBG];
  dcst_cnt_t ccd_l_next[NBG];
  dcst_cnt_t rrd_l_reg [NBG];
  dcst_cnt_t rrd_l_next[NBG];
  dcst_cnt_t wtr_l_reg [NBG];
  dcst_cnt_t wtr_l_next[NBG];
  dcst_cnt_t pre_reg   [NBK];
  dcst_cnt_t pre_next  [NBK];
  int        crc_add;

  // Write-to-read counts from the write command, so the burst is added
  always_comb begin
    // R10 R11 CRC and DM extension
    crc_add    = crc_dm_en_in ? CRC_DM_CYC : 0;
    // R02 cross-group column spacing
    ccd_s_next = tmr(ccd_s_reg, issue && is_col, CCD_S_CYC);
    // R03 cross-group activate spacing
    rrd_s_next = tmr(rrd_s_reg, issue && cmd_reg == DCST_ACT, RRD_S_CYC);
    // R06 cross-group write to read
    wtr_s_next = tmr(wtr_s_reg, issue && cmd_reg == DCST_WR, WR_END + WTR_S_CYC + crc_add);
    for (int g = 0; g < NBG; g++) begin
      // R01 same-group column spacing
      ccd_l_next[g] = tmr(ccd_l_reg[g], issue && is_col && bg_reg == BGW'(g), CCD_L_CYC);
      // R04 same-group activate spacing
      rrd_l_next[g] = tmr(rrd_l_reg[g], issue && cmd_reg == DCST_ACT && bg_reg == BGW'(g),
                          RRD_L_CYC);
      // R07 same-group write to read
      wtr_l_next[g] = tmr(wtr_l_reg[g], issue && cmd_reg == DCST_WR && bg_reg == BGW'(g),
                          WR_END + WTR_L_CYC + crc_add);
    end
    for (int b = 0; b < NBK; b++) begin
      // R08 read to precharge
      pre_next[b] = tmr(pre_reg[b], issue && cmd_reg == DCST_RD && bk == BKW'(b), RTP_CYC);
      // R09 write recovery; one issue a cycle, so no read load is lost
      if (issue && cmd_reg == DCST_WR && bk == BKW'(b)) begin
        pre_next[b] = tmr(pre_reg[b], 1'b1, WR_END + WR_CYC + crc_add);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ccd_s_reg <= '0;
      rrd_s_reg <= '0;
      wtr_s_reg <= '0;
      for (int g = 0; g < NBG; g++) begin
        ccd_l_reg[g] <= '0;
        rrd_l_reg[g] <= '0;
        wtr_l_reg[g] <= '0;
      end
      for (int b = 0; b < NBK; b++) pre_reg[b] <= '0;
    end else begin
      ccd_s_reg <= ccd_s_next;
      rrd_s_reg <= rrd_s_next;
      wtr_s_reg <= wtr_s_next;
      ccd_l_reg <= ccd_l_next;
      rrd_l_reg <= rrd_l_next;
      wtr_l_reg <= wtr_l_next;
      pre_reg   <= pre_next;
    end
  end

  // ----------------------------------------------------------------
  // Legality of the held command
  // ----------------------------------------------------------------
  assign faw.act = issue && (cmd_reg == DCST_ACT);

  always_comb begin
    case (cmd_reg)
      DCST_ACT: legal = (rrd_s_reg == '0) && (rrd_l_reg[bg_reg] == '0) && faw.allow;
      DCST_RD:  legal = (ccd_s_reg == '0) && (ccd_l_reg[bg_reg] == '0)
                        && (wtr_s_reg == '0) && (wtr_l_reg[bg_reg] == '0);
      DCST_WR:  legal = (ccd_s_reg == '0) && (ccd_l_reg[bg_reg] == '0);
      DCST_PRE: legal = (pre_reg[bk] == '0);
      default:  legal = 1'b1;
    endcase
  end

  dcst_faw #(
    .NACT (FAW_ACTS),
    .WIN  (FAW_CYC)
  ) u_faw (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .faw     (faw.win)
  );

  // ----------------------------------------------------------------
  // Checks: cycles since each issued column, activate, read and write command
  // ----------------------------------------------------------------
  dcst_cnt_t gcol_reg[NBG];
  dcst_cnt_t gact_reg[NBG];
  dcst_cnt_t gwr_reg [NBG];
  dcst_cnt_t grd_bk  [NBK];
  dcst_cnt_t gwr_bk  [NBK];

  function automatic dcst_cnt_t gap(input dcst_cnt_t cur, input logic ev);
    return ev ? CNT_W'(1) : ((cur == '1) ? cur : cur + 1'b1);
  endfunction : gap

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int g = 0; g < NBG; g++) begin
        gcol_reg[g] <= '1;
        gact_reg[g] <= '1;
        gwr_reg[g]  <= '1;
      end
      for (int b = 0; b < NBK; b++) begin
        grd_bk[b] <= '1;
        gwr_bk[b] <= '1;
      end
    end else begin
      for (int g = 0; g < NBG; g++) begin
        gcol_reg[g] <= gap(gcol_reg[g], issue && is_col && bg_reg == BGW'(g));
        gact_reg[g] <= gap(gact_reg[g], faw.act && bg_reg == BGW'(g));
        gwr_reg[g]  <= gap(gwr_reg[g], issue && cmd_reg == DCST_WR && bg_reg == BGW'(g));
      end
      for (int b = 0; b < NBK; b++) begin
        grd_bk[b] <= gap(grd_bk[b], issue && cmd_reg == DCST_RD && bk == BKW'(b));
        gwr_bk[b] <= gap(gwr_bk[b], issue && cmd_reg == DCST_WR && bk == BKW'(b));
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  ccd_same_a: assert property (issue && is_col |-> gcol_reg[bg_reg] >= CCD_L_CYC) // R01
    else $error("Same-group column spacing short");
  rrd_same_a: assert property (faw.act |-> gact_reg[bg_reg] >= RRD_L_CYC) // R04
    else $error("Same-group activate spacing short");
  wtr_same_a: assert property (issue && cmd_reg == DCST_RD |-> // R07 R11
    gwr_reg[bg_reg] >= WR_END + WTR_L_CYC + (crc_dm_en_in ? CRC_DM_CYC : 0))
    else $error("Same-group write to read short");
  rtp_pre_a: assert property (issue && cmd_reg == DCST_PRE |-> grd_bk[bk] >= RTP_CYC) // R08
    else $error("Read to precharge short");
  wr_pre_a: assert property (issue && cmd_reg == DCST_PRE |-> // R09
    gwr_bk[bk] >= WR_END + WR_CYC + (crc_dm_en_in ? CRC_DM_CYC : 0))
    else $error("Write recovery short");
  ready_back_a: assert property (issue |=> req_ready_out && !cmd_stb_out) // Back in idle the cycle after each issue
    else $error("Scheduler did not return to idle");

  for (genvar g = 0; g < NBG; g++) begin : g_cross
    for (genvar h = 0; h < NBG; h++) begin : g_other
      if (g != h) begin : g_chk
        ccd_diff_a: assert property (issue && is_col && bg_reg == BGW'(g) // R02
          |-> gcol_reg[h] >= CCD_S_CYC)
          else $error("Cross-group column spacing short");
        rrd_diff_a: assert property (faw.act && bg_reg == BGW'(g) // R03
          |-> gact_reg[h] >= RRD_S_CYC)
          else $error("Cross-group activate spacing short");
        wtr_diff_a: assert property (issue && cmd_reg == DCST_RD && bg_reg == BGW'(g) // R06 R10
          |-> gwr_reg[h] >= WR_END + WTR_S_CYC + (crc_dm_en_in ? CRC_DM_CYC : 0))
          else $error("Cross-group write to read short");
      end
    end
  end

  act_issue_c: cover property (faw.act ##[1:40] faw.act);
  wr_rd_c: cover property (issue && cmd_reg == DCST_WR ##[1:60] issue && cmd_reg == DCST_RD);
  wr_pre_c: cover property (issue && cmd_reg == DCST_WR ##[1:60] issue && cmd_reg == DCST_PRE);

endmodule : dcst_sched
`default_nettype wire
